// File: logic/swic_pkg.sv
package swic_pkg;

  // register map, byte addresses on apb
  localparam logic [7:0] ADDR_CTRL   = 8'h2C;  // interrupt_pin_and_sleep_wake_control
  localparam logic [7:0] ADDR_STATUS = 8'h30;  // system_mode_status and queue state
  localparam logic [7:0] ADDR_AUX    = 8'h34;  // auto-sleep enable and current rate code

  // control field positions
  localparam int BIT_QGATE = 7;
  localparam int BIT_TRANS = 6;
  localparam int BIT_ORIENT = 5;
  localparam int BIT_PULSE = 4;
  localparam int BIT_FFMT = 3;
  localparam int BIT_VECM = 2;
  localparam int BIT_POL = 1;
  localparam int BIT_DRIVE = 0;

  // status field positions
  localparam int BIT_ST_GERR  = 0;
  localparam int BIT_ST_SLEEP = 1;
  localparam int BIT_ST_GATED = 2;
  localparam int BIT_ST_LEVEL = 8;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int         NFUNC      = 5;   // transient, orient, pulse, ffmt, vecm
  localparam int         QDEPTH     = 32;
  localparam int         QAW        = 5;
  localparam int         SW         = 48;  // one x/y/z sample
  localparam logic [5:0] QCNT_ZERO  = 6'h00;
  localparam logic [5:0] QCNT_FULL  = 6'h20;
  localparam logic [5:0] QCNT_ONE   = 6'h01;

  typedef enum logic [1:0] {SWIC_WAKE, SWIC_SLEEP} swic_mode_e;

  // decoded control fields
  typedef struct packed {
    logic             qgate;
    logic [NFUNC-1:0] sleep_en;
    logic             pol;
    logic             drive;
  } swic_ctrl_s;

endpackage : swic_pkg

// File: logic/swic_qmem.sv
`timescale 1ns/1ps
// sample storage, registered read data
module swic_qmem (
  // clock
  input  wire logic                          pclk,
  input  wire logic                          ce,
  // write side
  input  wire logic                          we,
  input  wire logic [swic_pkg::QAW-1:0]      waddr,
  input  wire logic [swic_pkg::SW-1:0]       wdata,
  // read side
  input  wire logic [swic_pkg::QAW-1:0]      raddr,
  output logic      [swic_pkg::SW-1:0]       rdata
);
  import swic_pkg::*;

  logic [SW-1:0] mem [QDEPTH];

  // no reset: contents are meaningless until written
  always_ff @(posedge pclk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule : swic_qmem

// File: logic/swic_pinout.sv
`timescale 1ns/1ps
// one interrupt pin with polarity and drive type
module swic_pinout (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // control
  input  wire logic req,
  input  wire logic pol,
  input  wire logic drive,
  // pad
  output logic      pin_o,
  output logic      pin_oe_n
);
  import swic_pkg::*;

  wire lvl_asserted = pol;
  wire lvl_now      = req ? lvl_asserted : ~pol;
  // open-drain: drive only asserted level, else release
  wire drive_now    = ~drive | req;

  // reset state: push-pull, active low idle high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_o    <= 1'b1;
      pin_oe_n <= 1'b0;
    end else if (ce) begin
      pin_o    <= lvl_now;
      pin_oe_n <= ~drive_now;
    end
  end
endmodule : swic_pinout

// File: logic/swic_top.sv
`timescale 1ns/1ps
// Functional notes
// - gate clear: mode change flushes the queue
// - gate set: keep contents, refuse samples until empty
// - gated sample into unemptied queue raises error
// - error holds until queue emptied
// - transient bit keeps transient alive in sleep
// - orientation bit keeps orientation alive in sleep
// - pulse bit keeps pulse alive in sleep
// - freefall/motion bit keeps it alive in sleep
// - vector-magnitude bit keeps it alive in sleep
// - polarity bit: 0 active low, 1 high
// - drive bit: 0 push-pull, 1 open-drain
// - rate change flushes the queue
// - mode changes only with auto-sleep; reset counters
// - sources on one pin are ORed
module swic_top (
  // clock, enable, reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          ce,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // sample stream from the data path
  input  wire logic                          sample_valid,
  input  wire logic [swic_pkg::SW-1:0]       sample_data,
  input  wire logic [2:0]                    rate_code,
  // host drain port
  input  wire logic                          pop,
  output logic                               pop_valid,
  output logic      [swic_pkg::SW-1:0]       pop_data,
  // sleep controller
  input  wire logic                          autosleep_en,
  input  wire logic                          sleep_req,
  input  wire logic                          wake_req,
  output logic                               sleep_mode,
  output logic                               counters_clr,
  // detection functions
  input  wire logic [swic_pkg::NFUNC-1:0]    func_event,
  input  wire logic [swic_pkg::NFUNC-1:0]    func_route_a,
  output logic      [swic_pkg::NFUNC-1:0]    func_run,
  output logic                               wake_event,
  // interrupt pins
  output logic                               irq_pin_a_o,
  output logic                               irq_pin_a_oe_n,
  output logic                               irq_pin_b_o,
  output logic                               irq_pin_b_oe_n
);
  import swic_pkg::*;

  // limitations worth knowing before reuse:
  // - inputs are taken as same-domain, no synchronisers sit on them
  // - the apb answer adds no wait state: ready and error are flops loaded in the setup cycle, so every output is a flop
  // - a full queue drops new samples silently, there is no overrun flag
  // - events of a stopped function are dropped, not held for wake
  // registers
  logic [7:0]   ctrl_reg;
  swic_mode_e   mode_reg;
  logic         gated_reg;
  logic         gerr_reg;
  logic [2:0]   rate_reg;
  logic [QAW-1:0] wptr_reg;
  logic [QAW-1:0] rptr_reg;
  logic [5:0]   qcnt_reg;
  logic         pop_pend_reg;
  logic         irq_a_reg;
  logic         irq_b_reg;
  logic [NFUNC-1:0] run_reg;
  logic         wake_reg;
  logic         clr_reg;
  logic [31:0]  prdata_reg;
  logic         pready_reg;
  logic         pslverr_reg;
  logic         sleep_reg;

  // field decode
  swic_ctrl_s ctrl;
  assign ctrl.qgate    = ctrl_reg[BIT_QGATE];
  assign ctrl.sleep_en = {ctrl_reg[BIT_TRANS], ctrl_reg[BIT_ORIENT], ctrl_reg[BIT_PULSE],
                          ctrl_reg[BIT_FFMT], ctrl_reg[BIT_VECM]};
  assign ctrl.pol      = ctrl_reg[BIT_POL];
  assign ctrl.drive    = ctrl_reg[BIT_DRIVE];

  // apb decode; answer flags settle in the setup cycle
  wire apb_acc   = psel & penable;
  wire apb_wr    = apb_acc & pwrite;
  wire hit_ctrl  = (paddr == ADDR_CTRL);
  wire hit_stat  = (paddr == ADDR_STATUS);
  wire hit_aux   = (paddr == ADDR_AUX);
  wire hit_any   = hit_ctrl | hit_stat | hit_aux;
  wire ctrl_we   = apb_wr & hit_ctrl & pstrb[0];
  wire setup_ph  = psel & ~penable;
  wire bad_setup = setup_ph & (~hit_any | (pwrite & ~hit_ctrl));

  // mode transitions, only under auto-sleep
  // a function event wakes from sleep only if that function is kept alive; wake_req always wakes
  wire to_sleep  = autosleep_en & (mode_reg == SWIC_WAKE) & sleep_req;
  wire to_wake   = autosleep_en & (mode_reg == SWIC_SLEEP) &
                   (wake_req | (|(func_event & ctrl.sleep_en)));
  wire mode_chg  = to_sleep | to_wake;
  wire rate_chg  = (rate_code != rate_reg);

  // flush on rate change, or mode change with gate bypassed
  wire flush     = rate_chg | (mode_chg & ~ctrl.qgate);
  wire arm_gate  = mode_chg & ctrl.qgate;
  wire q_empty   = (qcnt_reg == QCNT_ZERO);
  wire q_full    = (qcnt_reg == QCNT_FULL);
  wire q_pop     = pop & ~q_empty & ~flush;
  wire drained   = q_empty | (q_pop & (qcnt_reg == QCNT_ONE));
  // refuse while gated; full queue also refuses
  wire q_push    = sample_valid & ~flush & ~gated_reg & ~arm_gate & ~q_full;
  wire gerr_set  = sample_valid & (gated_reg | arm_gate) & ~q_empty;
  // level bookkeeping kept apart from the pointers
  wire [5:0] qcnt_inc = {5'h00, q_push};
  wire [5:0] qcnt_dec = {5'h00, q_pop};

  // functions in sleep run only if their bit is set
  wire             in_sleep = (mode_reg == SWIC_SLEEP);
  wire [NFUNC-1:0] run_next;
  wire [NFUNC-1:0] live_ev;
  for (genvar f = 0; f < NFUNC; f++) begin : g_func
    assign run_next[f] = ~in_sleep | ctrl.sleep_en[f];
    // an event from a stopped function is dropped here
    assign live_ev[f]  = func_event[f] & run_next[f];
  end
  // wired-or of all sources routed to each pin
  wire irq_a_next = |(live_ev & func_route_a);
  wire irq_b_next = |(live_ev & ~func_route_a);

  // read mux
  wire [31:0] stat_word = {{(32-BIT_ST_LEVEL-6){1'b0}}, qcnt_reg, 5'h00,
                           gated_reg, (mode_reg == SWIC_SLEEP), gerr_reg};
  wire [31:0] aux_word  = {28'h0000000, rate_reg, autosleep_en};
  wire [31:0] rd_next   = hit_ctrl ? {24'h000000, ctrl_reg} :
                          hit_stat ? stat_word :
                          hit_aux  ? aux_word  : 32'h00000000;

  // control register, all zero at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ce && ctrl_we) begin
      ctrl_reg <= pwdata[7:0];
    end
  end

  // ready and error only in the access phase that follows a setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (ce) begin
      pready_reg  <= setup_ph;
      pslverr_reg <= bad_setup;
    end
  end

  // read data captured in setup, stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (ce && psel && !penable) begin
      prdata_reg <= rd_next;
    end
  end
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // rate follower; any difference from it flushes the queue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_reg <= '0;
    end else if (ce) begin
      rate_reg <= rate_code;
    end
  end

  // wake/sleep mode and counter clear pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= SWIC_WAKE;
      clr_reg  <= 1'b0;
      wake_reg <= 1'b0;
      sleep_reg <= 1'b0;
    end else if (ce) begin
      clr_reg  <= mode_chg;
      wake_reg <= to_wake;
      if (to_sleep) begin
        mode_reg  <= SWIC_SLEEP;
        sleep_reg <= 1'b1;
      end else if (to_wake) begin
        mode_reg  <= SWIC_WAKE;
        sleep_reg <= 1'b0;
      end
    end
  end

  // gate and error: a drain in the same cycle wins over set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gated_reg <= 1'b0;
      gerr_reg  <= 1'b0;
    end else if (ce) begin
      if (arm_gate && !drained) begin
        gated_reg <= 1'b1;
      end else if (drained || flush) begin
        gated_reg <= 1'b0;
      end
      if (gerr_set && !(q_pop && qcnt_reg == QCNT_ONE)) begin
        gerr_reg <= 1'b1;
      end else if (drained || flush) begin
        gerr_reg <= 1'b0;
      end
    end
  end

  // queue pointers and level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_reg     <= '0;
      rptr_reg     <= '0;
      qcnt_reg     <= QCNT_ZERO;
      pop_pend_reg <= 1'b0;
    end else if (ce) begin
      pop_pend_reg <= q_pop;
      if (flush) begin
        wptr_reg <= '0;
        rptr_reg <= '0;
        qcnt_reg <= QCNT_ZERO;
      end else begin
        if (q_push) begin
          wptr_reg <= wptr_reg + 1'b1;
        end
        if (q_pop) begin
          rptr_reg <= rptr_reg + 1'b1;
        end
        qcnt_reg <= qcnt_reg + qcnt_inc - qcnt_dec;
      end
    end
  end

  swic_qmem u_qmem (
    .pclk  (pclk),
    .ce    (ce),
    .we    (q_push),
    .waddr (wptr_reg),
    .wdata (sample_data),
    .raddr (rptr_reg),
    .rdata (pop_data)
  );
  assign pop_valid = pop_pend_reg;

  // function enables and pin requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg   <= '0;
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
    end else if (ce) begin
      run_reg   <= run_next;
      irq_a_reg <= irq_a_next;
      irq_b_reg <= irq_b_next;
    end
  end
  assign func_run     = run_reg;
  assign wake_event   = wake_reg;
  assign counters_clr = clr_reg;
  assign sleep_mode   = sleep_reg;

  // both pins share polarity and drive type; open-drain idles released,
  // so an active-high open-drain line needs a pull-down on the board
  swic_pinout u_pin_a (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .req      (irq_a_reg),
    .pol      (ctrl.pol),
    .drive    (ctrl.drive),
    .pin_o    (irq_pin_a_o),
    .pin_oe_n (irq_pin_a_oe_n)
  );

  swic_pinout u_pin_b (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .req      (irq_b_reg),
    .pol      (ctrl.pol),
    .drive    (ctrl.drive),
    .pin_o    (irq_pin_b_o),
    .pin_oe_n (irq_pin_b_oe_n)
  );
endmodule : swic_top

// File: tb/swic_chk.sv
`timescale 1ns/1ps
module swic_chk
  import swic_pkg::*;
(
  // clock and reset
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             ce,
  // apb
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [3:0]       pstrb,
  // mode and functions
  input wire logic             autosleep_en,
  input wire logic             sleep_mode,
  input wire logic             counters_clr,
  input wire logic             wake_event,
  input wire logic [NFUNC-1:0] func_event,
  input wire logic [NFUNC-1:0] func_route_a,
  input wire logic [NFUNC-1:0] func_run,
  // pins
  input wire logic             irq_pin_a_o,
  input wire logic             irq_pin_a_oe_n,
  input wire logic             irq_pin_b_o,
  input wire logic             irq_pin_b_oe_n
);
  logic [7:0] c_reg;
  wire wr_ctrl = ce && psel && penable && pwrite && paddr == ADDR_CTRL && pstrb[0];
  wire ev_a = |(func_event & func_route_a);
  wire ev_b = |(func_event & ~func_route_a);
  // shadow of the control register, so pins can be judged without a read
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) c_reg <= CTRL_RESET;
    else if (wr_ctrl) c_reg <= pwdata[7:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pp; !c_reg[0] && $stable(c_reg) |-> !irq_pin_a_oe_n && !irq_pin_b_oe_n; endproperty
  a_pp: assert property (p_pp) else $error("push-pull pin released");
  property p_od; c_reg[0] && $stable(c_reg) && !irq_pin_a_oe_n |-> irq_pin_a_o == c_reg[1]; endproperty
  a_od: assert property (p_od) else $error("open-drain drives idle level");
  property p_idle; (!ev_a && !c_reg[0] && $stable(c_reg))[*3] |-> irq_pin_a_o == !c_reg[1]; endproperty
  a_idle: assert property (p_idle) else $error("pin a asserted without cause");
  property p_ora; !sleep_mode && $stable(c_reg) && ev_a |-> ##2 irq_pin_a_o == c_reg[1] && !irq_pin_a_oe_n;
  endproperty
  a_ora: assert property (p_ora) else $error("pin a missed a source");
  property p_orb; !sleep_mode && $stable(c_reg) && ev_b |-> ##2 irq_pin_b_o == c_reg[1] && !irq_pin_b_oe_n;
  endproperty
  a_orb: assert property (p_orb) else $error("pin b missed a source");
  property p_asl; $changed(sleep_mode) |-> $past(autosleep_en); endproperty
  a_asl: assert property (p_asl) else $error("mode changed without auto-sleep");
  property p_clr; $changed(sleep_mode) |-> ##[0:1] counters_clr; endproperty
  a_clr: assert property (p_clr) else $error("no counter clear on mode change");
  property p_wev; $fell(sleep_mode) |-> wake_event; endproperty
  a_wev: assert property (p_wev) else $error("wake without wake pulse");
  property p_run_w; (!sleep_mode)[*2] |-> func_run == 5'h1F; endproperty
  a_run_w: assert property (p_run_w) else $error("function stopped in wake");
  property p_run_s; (sleep_mode && $stable(c_reg))[*2] |-> func_run == c_reg[6:2]; endproperty
  a_run_s: assert property (p_run_s) else $error("sleep run set wrong");
  c_gate: cover property (c_reg[7] && $changed(sleep_mode));
  c_od: cover property (c_reg[0] && irq_pin_a_oe_n);
  c_wake: cover property ($fell(sleep_mode));
endmodule : swic_chk
bind swic_top swic_chk i_chk (.*);

// File: tb/swic_host.sv
`timescale 1ns/1ps
module swic_host (
  // pads
  input wire logic irq_pin_a_o,
  input wire logic irq_pin_a_oe_n,
  input wire logic irq_pin_b_o,
  input wire logic irq_pin_b_oe_n,
  // host view
  input wire logic host_pol,
  output logic     a_act,
  output logic     b_act
);
  // a released pad floats to the board pull-up
  wire pad_a = irq_pin_a_oe_n ? 1'b1 : irq_pin_a_o;
  wire pad_b = irq_pin_b_oe_n ? 1'b1 : irq_pin_b_o;
  // active-high open-drain would need a pull-down, so it is not used
  assign a_act = pad_a == host_pol;
  assign b_act = pad_b == host_pol;
endmodule : swic_host

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import swic_pkg::*;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, sample_valid = 0, pop = 0, pop_valid, autosleep_en = 0;
  logic sleep_req = 0, wake_req = 0, sleep_mode, counters_clr, wake_event, host_pol = 0, a_act, b_act;
  logic [SW-1:0] sample_data = 0, pop_data;
  logic [2:0] rate_code = 0;
  logic [NFUNC-1:0] func_event = 0, func_route_a = 0, func_run;
  logic irq_pin_a_o, irq_pin_a_oe_n, irq_pin_b_o, irq_pin_b_oe_n;
  int n_errors = 0, samples_checked = 0, cyc = 0, seed = 44;
  logic [SW-1:0] q[$];
  swic_top i_dut (.*);
  swic_host i_host (.*);
  always #5 pclk = ~pclk;
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // a hang ends the run as a failure
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic chk(logic [47:0] seen, logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // one apb transfer; read data taken at the pready edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic push(logic take);
    logic [SW-1:0] s;
    s = SW'({$random(seed), $random(seed)});
    @(posedge pclk);
    {sample_valid, sample_data} <= {1'b1, s};
    @(posedge pclk);
    sample_valid <= 0;
    if (take) q.push_back(s);
  endtask : push
  // drain one sample and compare with the model queue
  task automatic pop1();
    @(posedge pclk);
    pop <= 1;
    @(posedge pclk);
    pop <= 0;
    @(posedge pclk);
    chk(pop_valid, q.size() != 0);
    if (q.size() != 0) chk(pop_data, q.pop_front());
  endtask : pop1
  task automatic slp(logic s);
    @(posedge pclk);
    {sleep_req, wake_req} <= {s, !s};
    @(posedge pclk);
    {sleep_req, wake_req} <= 2'b00;
    tick(2);
  endtask : slp
  task automatic fire(logic [NFUNC-1:0] ev);
    @(posedge pclk);
    func_event <= ev;
    @(posedge pclk);
    func_event <= 0;
    tick(2);
  endtask : fire
  initial begin
    tick(4);
    presetn <= 1;
    apb(0, ADDR_CTRL, 0);
    chk(rd, 0);
    for (int i = 0; i < 8; i++) begin
      apb(1, ADDR_CTRL, 32'h1 << i);
      apb(0, ADDR_CTRL, 0);
      chk(rd, 32'h1 << i);
    end
    apb(0, 8'h3C, 0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1, ADDR_CTRL, 0);
    // rate change drops stored samples
    repeat (3) push(1);
    pop1();
    rate_code <= 3'h5;
    q.delete();
    tick(2);
    pop1();
    autosleep_en <= 1;
    repeat (2) push(1);
    slp(1);
    q.delete();
    apb(0, ADDR_STATUS, 0);
    chk(rd[13:0], 14'h2);
    autosleep_en <= 0;
    slp(0);
    chk(sleep_mode, 1);
    autosleep_en <= 1;
    // only a function kept alive in sleep may wake
    for (int i = 0; i < NFUNC; i++) begin
      apb(1, ADDR_CTRL, 32'h4 << i);
      fire(NFUNC'(1 << ((i + 1) % NFUNC)));
      chk(sleep_mode, 1);
      fire(NFUNC'(1 << i));
      chk(sleep_mode, 0);
      slp(1);
    end
    apb(1, ADDR_CTRL, 32'h80);
    repeat (2) push(1);
    slp(0);
    push(0);
    apb(0, ADDR_STATUS, 0);
    chk(rd[13:0], 14'h205);
    repeat (2) pop1();
    apb(0, ADDR_STATUS, 0);
    chk(rd[2:0], 3'h0);
    push(1);
    pop1();
    // pin polarity, drive and source merging
    for (int k = 0; k < 3; k++) begin
      apb(1, ADDR_CTRL, k);
      host_pol <= k[1];
      func_route_a <= NFUNC'($random(seed));
      func_event <= NFUNC'($random(seed));
      tick(3);
      chk({a_act, b_act}, {|(func_event & func_route_a), |(func_event & ~func_route_a)});
      func_event <= 0;
      tick(3);
      chk({a_act, b_act}, 0);
    end
    report_and_stop();
  end
endmodule : tb_top
